/* File: src/wdtu_defines.vh */
// Constants of the watchdog timer unit: reset values, field codes, timings.
// Assumes inclusion by its bare name from the watchdog design files.
`ifndef WDTU_DEFINES_VH
`define WDTU_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define WDTU_CNT_W          16
`define WDTU_PRE_W          14

// ****************************************************************
// Prescaler ratios and select codes
// ****************************************************************
`define WDTU_DIV_LONG       16384
`define WDTU_DIV_SHORT      256
`define WDTU_SEL_LONG       1'b0
`define WDTU_SEL_SHORT      1'b1
`define WDTU_PRE_LONG_MAX   14'h3fff
`define WDTU_PRE_SHORT_MAX  14'h00ff

// ****************************************************************
// Default interval: 6.5 ms at a 10 MHz reference clock
// ****************************************************************
`define WDTU_DEF_INTERVAL_NS 6500000
`define WDTU_REF_CLK_MHZ     10
`define WDTU_DEF_CYCLES \
  ((`WDTU_DEF_INTERVAL_NS * `WDTU_REF_CLK_MHZ) / 1000)
`define WDTU_DEF_TICKS      (`WDTU_DEF_CYCLES / `WDTU_DIV_SHORT)
`define WDTU_RST_DIV_SEL    `WDTU_SEL_SHORT
`define WDTU_RST_RELOAD     (65536 - `WDTU_DEF_TICKS)

// ****************************************************************
// Prewarning to reset request delay at the 20 MHz system clock
// ****************************************************************
`define WDTU_SYS_CLK_MHZ    20
`define WDTU_PREWARN_NS     1000
`define WDTU_PREWARN_CYCLES \
  ((`WDTU_PREWARN_NS * `WDTU_SYS_CLK_MHZ) / 1000)

// ****************************************************************
// Sequencer states
// ****************************************************************
`define WDTU_ST_RUN         2'h0
`define WDTU_ST_PREWARN     2'h1
`define WDTU_ST_RESET       2'h2

`endif

/* File: src/wdtu_prescaler.v */
// Watchdog prescaler: divides the system clock by 16384 or 256.
// Assumes one system clock; run and clear come from the watchdog core.
`timescale 1ns/1ps
`include "wdtu_defines.vh"

module wdtu_prescaler (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        reset_n_i,
  // Control
  input  wire        run_i,
  input  wire        clear_i,
  input  wire        div_sel_i,
  // Tick out
  output wire        tick_o
);

  reg  [`WDTU_PRE_W-1:0] pre_q;
  reg  [`WDTU_PRE_W-1:0] pre_d;
  wire [`WDTU_PRE_W-1:0] pre_max;

  // ****************************************************************
  // Divider
  // ****************************************************************
  assign pre_max = (div_sel_i == `WDTU_SEL_SHORT) ? `WDTU_PRE_SHORT_MAX
                                                  : `WDTU_PRE_LONG_MAX;
  assign tick_o  = run_i & ~clear_i & (pre_q >= pre_max);

  always @* begin
    pre_d = pre_q;
    if (clear_i) begin
      pre_d = {`WDTU_PRE_W{1'b0}};
    end else if (run_i) begin
      if (pre_q >= pre_max) begin
        pre_d = {`WDTU_PRE_W{1'b0}};
      end else begin
        pre_d = pre_q + 14'h0001;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pre_q <= {`WDTU_PRE_W{1'b0}};
    end else begin
      pre_q <= pre_d;
    end
  end

endmodule

/* File: src/wdtu_top.v */
// Watchdog timer unit: 16-bit up counter, prescaler, prewarning and reset.
// Assumes commands arrive as one-cycle pulses on the 20 MHz system clock.
`timescale 1ns/1ps
`include "wdtu_defines.vh"

module wdtu_top #(
  parameter CNT_W          = `WDTU_CNT_W,
  parameter PREWARN_CYCLES = `WDTU_PREWARN_CYCLES
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             reset_n_i,
  // Processor commands, one-cycle pulses
  input  wire             wd_service_cmd_i,
  input  wire             wd_disable_cmd_i,
  input  wire             wd_enable_cmd_i,
  // Configuration write
  input  wire             cfg_wr_i,
  input  wire [CNT_W-1:0] wd_reload_value_i,
  input  wire             cfg_div_sel_i,
  // Status
  output wire             wd_enabled_o,
  output wire [CNT_W-1:0] wd_count_o,
  output wire [CNT_W-1:0] wd_reload_o,
  output wire             wd_div_sel_o,
  // Fault outputs
  output wire             prewarn_irq_o,
  output wire             reset_req_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg              en_q;
  reg              en_d;
  reg [CNT_W-1:0]  cnt_q;
  reg [CNT_W-1:0]  cnt_d;
  reg [CNT_W-1:0]  reload_q;
  reg              sel_q;
  reg [1:0]        st_q;
  reg [1:0]        st_d;
  reg [15:0]       wait_q;
  reg [15:0]       wait_d;
  reg              prewarn_q;
  reg              rstreq_q;
  wire             tick;
  wire             ovf;
  wire             run;

  // ****************************************************************
  // Local constants
  // ****************************************************************
  // Sequencer states
  localparam [1:0]  ST_RUN     = `WDTU_ST_RUN;
  localparam [1:0]  ST_PREWARN = `WDTU_ST_PREWARN;
  localparam [1:0]  ST_RESET   = `WDTU_ST_RESET;
  // Sized copies, so that no assignment truncates a bare integer
  localparam [31:0] RST_RELOAD = `WDTU_RST_RELOAD;
  localparam [31:0] PW_LAST    = PREWARN_CYCLES - 1;

  // ****************************************************************
  // State decoding
  // ****************************************************************
  // True once the reset request has been raised
  function is_halted;
    input [1:0] s;
    begin
      is_halted = (s == ST_RESET);
    end
  endfunction

  // True while any fault output must be high
  function is_faulted;
    input [1:0] s;
    begin
      is_faulted = (s == ST_PREWARN) || (s == ST_RESET);
    end
  endfunction

  // ****************************************************************
  // Enable control
  // ****************************************************************
  // Enable wins when both commands arrive in one cycle
  always @* begin
    en_d = en_q;
    if (wd_disable_cmd_i) begin
      en_d = 1'b0;
    end
    if (wd_enable_cmd_i) begin
      en_d = 1'b1;
    end
  end

  // Counting stops once the reset request is raised
  assign run = en_q & ~is_halted(st_q);

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  wdtu_prescaler u_pre (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .run_i     (run),
    .clear_i   (wd_service_cmd_i),
    .div_sel_i (sel_q),
    .tick_o    (tick)
  );

  // ****************************************************************
  // Counter
  // ****************************************************************
  assign ovf = tick & (cnt_q == {CNT_W{1'b1}});

  // Service has priority over the reload on overflow
  always @* begin
    cnt_d = cnt_q;
    if (wd_service_cmd_i) begin
      cnt_d = reload_q;
    end else if (ovf) begin
      cnt_d = reload_q;
    end else if (tick) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************************************
  // Overflow sequencer
  // ****************************************************************
  always @* begin
    st_d   = st_q;
    wait_d = wait_q;
    case (st_q)
      ST_RUN: begin
        wait_d = 16'h0000;
        if (ovf && !wd_service_cmd_i) begin
          st_d = ST_PREWARN;
        end
      end
      ST_PREWARN: begin
        if (wait_q >= PW_LAST[15:0]) begin
          st_d = ST_RESET;
        end else begin
          wait_d = wait_q + 16'h0001;
        end
      end
      ST_RESET: begin
        st_d = ST_RESET;
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      en_q   <= 1'b1;
      cnt_q  <= RST_RELOAD[CNT_W-1:0];
      st_q   <= ST_RUN;
      wait_q <= 16'h0000;
    end else begin
      en_q   <= en_d;
      cnt_q  <= cnt_d;
      st_q   <= st_d;
      wait_q <= wait_d;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // A new reload value reaches the counter only at the next reload
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reload_q <= RST_RELOAD[CNT_W-1:0];
      sel_q    <= `WDTU_RST_DIV_SEL;
    end else if (cfg_wr_i) begin
      reload_q <= wd_reload_value_i;
      sel_q    <= cfg_div_sel_i;
    end
  end

  // ****************************************************************
  // Fault outputs
  // ****************************************************************
  // Taken from the next state, so they rise with the state change
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      prewarn_q <= 1'b0;
      rstreq_q  <= 1'b0;
    end else begin
      prewarn_q <= is_faulted(st_d);
      rstreq_q  <= is_halted(st_d);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wd_enabled_o  = en_q;
  assign wd_count_o    = cnt_q;
  assign wd_reload_o   = reload_q;
  assign wd_div_sel_o  = sel_q;
  assign prewarn_irq_o = prewarn_q;
  assign reset_req_o   = rstreq_q;

endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the watchdog unit.
// Assumes src/ design files; shortened prewarning delay.
`timescale 1ns/1ps
module testbench;
  localparam PW = 2;
  reg         mclk = 1'b0;
  reg         reset_n = 1'b0;
  wire        svc, dis, ena, cwr, sel, en, sel_o, pw, rq;
  wire [15:0] rl, cnt, rl_o;
  reg  [15:0] c0;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     n;
  always #25 mclk = ~mclk;
  wdtu_cpu_model cpu (.mclk_i(mclk), .service_o(svc), .disable_o(dis),
    .enable_o(ena), .cfg_wr_o(cwr), .reload_o(rl), .div_sel_o(sel));
  wdtu_top #(.PREWARN_CYCLES(PW)) DUT (.mclk_i(mclk), .reset_n_i(reset_n),
    .wd_service_cmd_i(svc), .wd_disable_cmd_i(dis), .wd_enable_cmd_i(ena),
    .cfg_wr_i(cwr), .wd_reload_value_i(rl), .cfg_div_sel_i(sel),
    .wd_enabled_o(en), .wd_count_o(cnt), .wd_reload_o(rl_o),
    .wd_div_sel_o(sel_o), .prewarn_irq_o(pw), .reset_req_o(rq));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task check(input string nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Edges until the count moves; running out is a timeout
  task wait_chg(input integer lim);
    begin
      c0 = cnt;
      n = 0;
      while (cnt === c0 && n < lim) begin
        @(posedge mclk) #1;
        n = n + 1;
      end
      if (cnt === c0) begin
        errors = errors + 1;
        $display("BAD timeout expected change seen %h", cnt);
        end_of_test;
      end
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset(input integer k);
    begin
      @(posedge mclk) #1;
      reset_n = 1'b0;
      repeat (k) @(posedge mclk);
      #1 reset_n = 1'b1;
      check("state", 16'h1, {en, sel_o, pw, rq} == 4'hc);
      check("count", 16'hff03, cnt);
      check("reload", 16'hff03, rl_o);
    end
  endtask
  task t_short;
    begin
      repeat (100) @(posedge mclk);
      cpu.pulse(4'h8, 16'h0, 1'b0);
      check("serviced", 16'hff03, cnt);
      wait_chg(300);
      check("ticks", 16'd256, n[15:0]);
      check("step", 16'hff04, cnt);
    end
  endtask
  task t_dis;
    begin
      cpu.pulse(4'h4, 16'h0, 1'b0);
      check("off", 16'h0, {15'h0, en});
      c0 = cnt;
      repeat (300) @(posedge mclk);
      check("held", c0, cnt);
      cpu.pulse(4'h6, 16'h0, 1'b0);
      check("on", 16'h1, {15'h0, en});
      wait_chg(300);
      check("resumed", c0 + 16'h1, cnt);
    end
  endtask
  task t_long;
    begin
      cpu.pulse(4'h1, 16'h1234, 1'b0);
      check("cfg", 16'h1234, rl_o);
      cpu.pulse(4'h8, 16'h0, 1'b1);
      check("loaded", 16'h1234, cnt);
      wait_chg(17000);
      check("long", 16'd16384, n[15:0]);
    end
  endtask
  task t_ovf;
    begin
      cpu.pulse(4'h1, 16'hfffe, 1'b1);
      cpu.pulse(4'h8, 16'h0, 1'b0);
      wait_chg(300);
      wait_chg(300);
      check("wrap", 16'hfffe, cnt);
      check("warn", 16'h2, {pw, rq});
      repeat (PW) @(posedge mclk);
      #1 check("request", 16'h3, {pw, rq});
    end
  endtask
  // Unserviced from reset: 253 ticks of 256 cycles to the prewarning
  task t_default;
    begin
      n = 0;
      while (pw !== 1'b1 && n < 70000) begin
        @(posedge mclk) #1;
        n = n + 1;
      end
      check("interval", 16'd64768, n[15:0]);
      check("first warn", 16'h2, {14'h0, pw, rq});
    end
  endtask
  initial begin
    t_reset(16);
    t_short;
    t_dis;
    t_long;
    t_ovf;
    t_reset(2);
    t_default;
    end_of_test;
  end
endmodule

/* File: testbench/wdtu_cpu_model.sv */
// Processor model issuing watchdog commands.
// Assumes the bench calls pulse; drives 1 ns after the rising edge.
`timescale 1ns/1ps
module wdtu_cpu_model (
  // Clock
  input  wire        mclk_i,
  // Commands
  output reg         service_o,
  output reg         disable_o,
  output reg         enable_o,
  output reg         cfg_wr_o,
  output reg  [15:0] reload_o,
  output reg         div_sel_o
);
  initial {service_o, disable_o, enable_o, cfg_wr_o} = 4'h0;
  initial {reload_o, div_sel_o} = 17'h0;
  // Bits of c: service, disable, enable, config write
  task pulse(input [3:0] c, input [15:0] v, input s);
    begin
      @(posedge mclk_i) #1;
      {service_o, disable_o, enable_o, cfg_wr_o} = c;
      reload_o = v;
      div_sel_o = s;
      @(posedge mclk_i) #1;
      {service_o, disable_o, enable_o, cfg_wr_o} = 4'h0;
      reload_o = ~v;
      div_sel_o = ~s;
    end
  endtask
endmodule

/* File: testbench/wdtu_top_properties.sv */
// Checker of the watchdog unit, watching the top ports only.
// Assumes one clock and a reset held for two edges or more.
`timescale 1ns/1ps
module wdtu_checker #(
  parameter     CNT_W          = 16,
  parameter int PREWARN_CYCLES = 20
) (
  // Clock and reset
  input wire             mclk_i,
  input wire             reset_n_i,
  // Watched ports
  input wire             wd_service_cmd_i,
  input wire             wd_disable_cmd_i,
  input wire             wd_enable_cmd_i,
  input wire             cfg_wr_i,
  input wire [CNT_W-1:0] wd_reload_value_i,
  input wire             cfg_div_sel_i,
  input wire             wd_enabled_o,
  input wire [CNT_W-1:0] wd_count_o,
  input wire [CNT_W-1:0] wd_reload_o,
  input wire             wd_div_sel_o,
  input wire             prewarn_irq_o,
  input wire             reset_req_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  chk_reset_state: assert property (
    $rose(reset_n_i) |-> wd_enabled_o && wd_count_o == 16'hff03
    && wd_reload_o == 16'hff03 && wd_div_sel_o) else $error("reset state");
  chk_cfg_write: assert property (
    cfg_wr_i |=> wd_reload_o == $past(wd_reload_value_i)
    && wd_div_sel_o == $past(cfg_div_sel_i)) else $error("config write");
  chk_service_load: assert property (
    wd_service_cmd_i && !cfg_wr_i && !reset_req_o
    |=> wd_count_o == $past(wd_reload_o)) else $error("service load");
  chk_enable_cmd: assert property (
    wd_enable_cmd_i |=> wd_enabled_o) else $error("enable");
  chk_disable_cmd: assert property (
    wd_disable_cmd_i && !wd_enable_cmd_i |=> !wd_enabled_o)
    else $error("disable");
  chk_hold_disabled: assert property (
    !wd_enabled_o && !wd_service_cmd_i |=> $stable(wd_count_o))
    else $error("count moved while off");
  chk_count_step: assert property (
    $changed(wd_count_o) && !$past(wd_service_cmd_i) |->
    wd_count_o == $past(wd_count_o) + 16'h1 || $past(wd_count_o) == 16'hffff)
    else $error("count step");
  chk_prewarn_wrap: assert property (
    $rose(prewarn_irq_o) |-> $past(wd_count_o) == 16'hffff && !reset_req_o
    && wd_count_o == wd_reload_o) else $error("prewarning cause");
  chk_req_delay: assert property (
    $rose(prewarn_irq_o) |-> ##PREWARN_CYCLES $rose(reset_req_o))
    else $error("reset request delay");
  chk_fault_hold: assert property (
    prewarn_irq_o |=> prewarn_irq_o) else $error("prewarning dropped");
  chk_req_order: assert property (
    reset_req_o |-> prewarn_irq_o) else $error("request without warning");
endmodule

bind wdtu_top wdtu_checker #(
  .CNT_W(CNT_W), .PREWARN_CYCLES(PREWARN_CYCLES)) u_chk (
  .mclk_i, .reset_n_i, .wd_service_cmd_i, .wd_disable_cmd_i,
  .wd_enable_cmd_i, .cfg_wr_i, .wd_reload_value_i, .cfg_div_sel_i,
  .wd_enabled_o, .wd_count_o, .wd_reload_o, .wd_div_sel_o,
  .prewarn_irq_o, .reset_req_o);
